// file: logic/asro_pkg.sv
// package: frame layout, timing counts and state enums for the serial result output link
// What this block does
// - result frame is exactly 24 shift clocks
// - three status, seventeen result, four zero bits
// - extra shift clocks beyond 24 output one
// - chip select high mid-frame aborts, restarts conversion
// - bit 23 is active-low conversion complete flag
// - bit 22 filler always low
// - bit 21 polarity, high for zero or positive
// - bits 21,20 both high overrange, both low underrange
// - bits 20 to 4 signed value, MSB first
// - bits 3 to 0 always low
// - chip select high: output released, clocks ignored
// - host lowers select; flag shown live
// - flag sampled first rise; bit 22 first fall
// - last bit on 23rd fall, latched 24th rise
// - 24th fall drives next cycle's completion flag
// - out of range clamps to one step beyond
// - in-range codes follow offset binary pattern
// - host uses falling flag as result ready
// - clock mode strapped by shift clock pin level
// - select high before first rise: sleep, keep result
package asro_pkg;
   localparam int FRAME_BITS = 24;
   localparam int CNT_W = 6;
   localparam int VAL_W = 17;
   localparam int FLAG_POS = 23;
   localparam int FILL_POS = 22;
   localparam int POL_POS = 21;
   localparam int VAL_MSB = 20;
   localparam int VAL_LSB = 4;
   localparam int ZERO_BITS = 4;
   localparam logic [CNT_W-1:0] CNT_RST = 6'h00;
   // conversion length in system clock cycles (shortened model of analog time)
   localparam int CONV_CYCLES = 64;
   // internal shift clock half period in system clocks (80 ns at 4 ns)
   localparam int SCK_HALF_NS = 80;
   localparam int CLK_NS = 4;
   localparam int SCK_HALF_CYC = SCK_HALF_NS / CLK_NS;
   // host register offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_DATA = 8'h08;
   localparam int CTRL_START = 0;
   localparam int CTRL_ABORT_AT = 8;
   localparam int CTRL_ABORT_EN = 16;
   localparam int CTRL_EXTRA = 24;
   typedef enum logic [1:0] {ASRO_CONV, ASRO_SLEEP, ASRO_OUT} asro_state_t;
   typedef enum logic [1:0] {ASRO_IDLE, ASRO_LOW, ASRO_HIGH, ASRO_DONE} asro_hstate_t;
endpackage

// file: logic/asro_if.sv
// interface: three-wire link between converter and host
`timescale 1ns/1ps
interface asro_if;
   logic cs_n;          // chip select, active low, host drives
   logic sck_host;      // shift clock driven by host
   logic sck_host_oe;   // host drives shift clock
   logic sck_dev;       // shift clock driven by converter (internal mode)
   logic sck_dev_oe;    // converter drives shift clock
   logic serial_out;    // data from converter
   logic serial_out_oe; // converter drives data
   logic sck;           // resolved shift clock level
   logic data;          // resolved data level (pull-up when released)
   assign sck = sck_dev_oe ? sck_dev : (sck_host_oe ? sck_host : 1'b1);
   assign data = serial_out_oe ? serial_out : 1'b1;
   modport dev (input cs_n, input sck, output sck_dev, output sck_dev_oe,
                output serial_out, output serial_out_oe);
   modport host (output cs_n, output sck_host, output sck_host_oe, input sck, input data);
endinterface

// file: logic/asro_sync.sv
// two-flop synchroniser with edge detection on the second stage
`timescale 1ns/1ps
module asro_sync
   import asro_pkg::*;
(
   input wire logic clk_i,    // system clock
   input wire logic rstn_i,   // async reset, active low
   input wire logic d_i,      // async level
   input wire logic init_i,   // unused; every stage resets to one
   output logic q_o,          // synchronised level
   output logic rise_o,       // one-cycle rising pulse
   output logic fall_o        // one-cycle falling pulse
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   // reset constants only; init_i is unused and every stage resets to one
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
      end else begin
         s1_q <= d_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   assign q_o = s2_q;
   assign rise_o = s2_q & ~s3_q;
   assign fall_o = ~s2_q & s3_q;
   logic unused_init;
   assign unused_init = init_i;
endmodule

// file: logic/asro_dev.sv
// converter end: conversion timing, frame building and serial shifting
//
// Local design decisions: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module asro_dev
   import asro_pkg::*;
#(
   parameter int CONV_LEN = CONV_CYCLES
)(
   input wire logic CLK_I,                  // system clock, 250 MHz
   input wire logic RSTN_I,                 // async reset, active low
   input wire logic SRST_I,                 // synchronous reset, active high
   input wire logic signed [VAL_W:0] VIN_I, // analog stand-in, wider to show range
   input wire logic signed [VAL_W:0] FS_I,  // positive full scale code
   output logic CONV_DONE_O,                // pulse: conversion complete
   output logic INT_MODE_O,                 // strapped internal clock mode
   asro_if.dev lnk                          // link pins
);
   logic cs_n;
   logic cs_fall;
   logic cs_rise;
   logic sck;
   logic sck_rise;
   logic sck_fall;

   // pins pass two flops before any logic reads them
   asro_sync u_cs (.clk_i(CLK_I), .rstn_i(RSTN_I), .d_i(lnk.cs_n), .init_i(1'b1),
                   .q_o(cs_n), .rise_o(cs_rise), .fall_o(cs_fall));
   asro_sync u_sck (.clk_i(CLK_I), .rstn_i(RSTN_I), .d_i(lnk.sck), .init_i(1'b1),
                    .q_o(sck), .rise_o(sck_rise), .fall_o(sck_fall));

   ////////////////////////////////////////////////////////////////////////////
   asro_state_t st_q;
   logic [15:0] conv_cnt_q;
   logic [FRAME_BITS-1:0] shreg_q;
   logic [CNT_W-1:0] bit_cnt_q;
   logic started_q;
   logic int_mode_q;
   logic [1:0] strap_q;
   logic [7:0] div_q;
   logic sck_o_q;
   logic sdo_q;
   logic sdo_oe_q;
   logic sck_oe_q;
   logic done_q;

   // combinational helpers
   logic conv_end;
   logic [FRAME_BITS-1:0] frame;
   logic eff_rise;
   logic eff_fall;

   // clamp and code the result into a frame; flag slot filled at load
   function automatic logic [FRAME_BITS-1:0] build_frame(input logic signed [VAL_W:0] v,
                                                         input logic signed [VAL_W:0] fs);
      logic pol;
      logic [VAL_W-1:0] code;
      pol = 1'b1;
      code = '0;
      // clamps carry their own polarity, so bits 21 and 20 agree on the range
      if (v >= fs) begin
         pol = 1'b1;
         code = {1'b1, {(VAL_W-1){1'b0}}};
      end else if (v < -fs) begin
         pol = 1'b0;
         code = {1'b0, {(VAL_W-1){1'b1}}};
      end else if (v >= 0) begin
         pol = 1'b1;
         code = {1'b0, v[VAL_W-2:0]};
      end else begin
         pol = 1'b0;
         code = {1'b1, v[VAL_W-2:0]};
      end
      build_frame = {1'b0, 1'b0, pol, code, {ZERO_BITS{1'b0}}};
   endfunction

   // divider has reached the end of a half period
   function automatic logic half_end(input logic [7:0] cnt);
      half_end = (cnt == 8'(SCK_HALF_CYC - 1));
   endfunction

   assign frame = build_frame(VIN_I, FS_I);
   assign conv_end = (st_q == ASRO_CONV) && (conv_cnt_q == 16'(CONV_LEN - 1));
   // in internal mode the edges come from our own divider, not the pin
   assign eff_rise = int_mode_q ? (sck_o_q == 1'b0 && half_end(div_q)) : sck_rise;
   assign eff_fall = int_mode_q ? (sck_o_q == 1'b1 && half_end(div_q)) : sck_fall;

   ////////////////////////////////////////////////////////////////////////////
   // conversion / sleep / output sequencing
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         st_q <= ASRO_CONV;
         conv_cnt_q <= 16'h0000;
         done_q <= 1'b0;
      end else if (SRST_I) begin
         st_q <= ASRO_CONV;
         conv_cnt_q <= 16'h0000;
         done_q <= 1'b0;
      end else begin
         done_q <= conv_end;
         unique case (st_q)
            ASRO_CONV: begin
               conv_cnt_q <= conv_cnt_q + 16'h0001;
               if (conv_end) st_q <= ASRO_SLEEP;
            end
            ASRO_SLEEP: begin
               if (!cs_n) st_q <= ASRO_OUT;
            end
            ASRO_OUT: begin
               // a select rise before any rising clock keeps the held result
               if (cs_rise && started_q) begin
                  st_q <= ASRO_CONV;
                  conv_cnt_q <= 16'h0000;
               end else if (cs_rise) begin
                  st_q <= ASRO_SLEEP;
               end else if (eff_fall && bit_cnt_q == 6'(FRAME_BITS - 1)) begin
                  st_q <= ASRO_CONV;
                  conv_cnt_q <= 16'h0000;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // strap: shift clock level at reset release and at each select fall
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         strap_q <= 2'h0;
         int_mode_q <= 1'b0;
      end else begin
         // keep sampling until the synchroniser shows the real pin level
         if (strap_q != 2'h3) strap_q <= strap_q + 2'h1;
         // clock held low by the host: external; released (pull-up): internal
         if (strap_q != 2'h3 || cs_fall) int_mode_q <= sck;
      end
   end

   // internal shift clock divider, runs only while outputting in internal mode
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         div_q <= 8'h00;
         sck_o_q <= 1'b1;
      end else if (int_mode_q && st_q == ASRO_OUT && !cs_n) begin
         if (half_end(div_q)) begin
            div_q <= 8'h00;
            sck_o_q <= ~sck_o_q;
         end else begin
            div_q <= div_q + 8'h01;
         end
      end else begin
         div_q <= 8'h00;
         sck_o_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // shifter and frame bit counter
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         shreg_q <= '0;
         bit_cnt_q <= CNT_RST;
         started_q <= 1'b0;
      end else if (SRST_I) begin
         shreg_q <= '0;
         bit_cnt_q <= CNT_RST;
         started_q <= 1'b0;
      end else if (conv_end) begin
         // the shifter fills with ones; clocks past the frame read one because the 24th fall has left ASRO_OUT,
         // and its top bit doubles as the completion flag in ASRO_OUT
         shreg_q <= frame;                                       // result held while asleep
         bit_cnt_q <= CNT_RST;
         started_q <= 1'b0;
      end else if (st_q == ASRO_OUT && !cs_n) begin
         if (eff_rise) started_q <= 1'b1;
         if (eff_fall && started_q) begin
            shreg_q <= {shreg_q[FRAME_BITS-2:0], 1'b1};
            bit_cnt_q <= bit_cnt_q + 6'h01;
         end
      end else if (st_q == ASRO_CONV) begin
         bit_cnt_q <= CNT_RST;
         started_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin drive, registered
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         sdo_q <= 1'b1;
         sdo_oe_q <= 1'b0;
         sck_oe_q <= 1'b0;
      end else begin
         // clock drive follows the synchronised select, never the raw pin
         sck_oe_q <= int_mode_q & ~cs_n;
         sdo_oe_q <= ~cs_n;
         if (st_q == ASRO_OUT) sdo_q <= shreg_q[FLAG_POS];
         else sdo_q <= 1'b1;                                     // flag high while converting
         // extra clocks after the frame read one
      end
   end

   assign lnk.serial_out = sdo_q;
   assign lnk.serial_out_oe = sdo_oe_q;
   assign lnk.sck_dev = sck_o_q;
   assign lnk.sck_dev_oe = sck_oe_q;
   assign CONV_DONE_O = done_q;
   assign INT_MODE_O = int_mode_q;
endmodule

// file: logic/asro_host.sv
// host end: AHB-Lite register slave driving the three-wire read sequence
`timescale 1ns/1ps
module asro_host
   import asro_pkg::*;
(
   input wire logic CLK_I,            // system clock
   input wire logic RSTN_I,           // async reset, active low
   input wire logic HSEL_I,           // AHB select
   input wire logic [7:0] HADDR_I,    // AHB address
   input wire logic [1:0] HTRANS_I,   // AHB transfer type
   input wire logic HWRITE_I,         // AHB write
   input wire logic [2:0] HSIZE_I,    // AHB size (word only)
   input wire logic [31:0] HWDATA_I,  // AHB write data
   input wire logic HREADY_I,         // AHB ready in
   output logic [31:0] HRDATA_O,      // AHB read data
   output logic HREADYOUT_O,          // AHB ready out, always high
   output logic HRESP_O,              // AHB response, always OKAY
   asro_if.host lnk                   // link pins
);
   logic data_s;
   logic data_fall;
   asro_sync u_d (.clk_i(CLK_I), .rstn_i(RSTN_I), .d_i(lnk.data), .init_i(1'b1),
                  .q_o(data_s), .rise_o(), .fall_o(data_fall));
   logic sck_s;
   logic sck_rise;
   asro_sync u_k (.clk_i(CLK_I), .rstn_i(RSTN_I), .d_i(lnk.sck), .init_i(1'b1),
                  .q_o(sck_s), .rise_o(sck_rise), .fall_o());

   ////////////////////////////////////////////////////////////////////////////
   logic wr_q;
   logic [7:0] addr_q;
   logic [31:0] rdata_q;
   logic [31:0] frame_q;
   logic [5:0] abort_at_q;
   logic abort_en_q;
   logic [5:0] total_q;
   logic [5:0] cnt_q;
   logic [7:0] div_q;
   logic sck_q;
   logic cs_n_q;
   logic busy_q;
   logic ready_q;
   logic start;
   asro_hstate_t hs_q;

   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         wr_q <= 1'b0;
         addr_q <= 8'h00;
      end else if (HREADY_I) begin
         wr_q <= HSEL_I & HTRANS_I[1] & HWRITE_I;
         addr_q <= HADDR_I;
      end
   end
   assign start = wr_q && addr_q == REG_CTRL && HWDATA_I[CTRL_START] && hs_q == ASRO_IDLE;

   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         abort_at_q <= 6'h00;
         abort_en_q <= 1'b0;
         total_q <= 6'h18;
      end else if (wr_q && addr_q == REG_CTRL) begin
         abort_at_q <= HWDATA_I[CTRL_ABORT_AT +: 6];
         abort_en_q <= HWDATA_I[CTRL_ABORT_EN];
         total_q <= 6'(FRAME_BITS) + {2'b00, HWDATA_I[CTRL_EXTRA +: 4]};
      end
   end

   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) rdata_q <= 32'h00000000;
      else if (HSEL_I && HTRANS_I[1] && !HWRITE_I && HREADY_I) begin
         unique case (HADDR_I)
            REG_STAT: rdata_q <= {29'h0, ready_q, busy_q, data_s};
            REG_DATA: rdata_q <= frame_q;
            REG_CTRL: rdata_q <= {4'h0, 4'(total_q - 6'(FRAME_BITS)), 7'h0,
                                  abort_en_q, 2'h0, abort_at_q, 8'h00};
            default: rdata_q <= 32'h00000000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read sequence: select low, wait for flag low, clock out the frame
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         hs_q <= ASRO_IDLE;
         cs_n_q <= 1'b1;
         sck_q <= 1'b0;
         div_q <= 8'h00;
         cnt_q <= 6'h00;
         frame_q <= 32'h00000000;
         busy_q <= 1'b0;
         ready_q <= 1'b0;
      end else begin
         unique case (hs_q)
            ASRO_IDLE: if (start) begin
               cs_n_q <= 1'b0;
               busy_q <= 1'b1;
               ready_q <= 1'b0;
               cnt_q <= 6'h00;
               div_q <= 8'h00;
               hs_q <= ASRO_LOW;
            end
            ASRO_LOW: begin
               div_q <= div_q + 8'h01;
               if (div_q == 8'(SCK_HALF_CYC - 1)) begin
                  div_q <= 8'h00;
                  // abort before the rise: a count of zero is a bare select pulse
                  if (abort_en_q && cnt_q == abort_at_q) begin
                     hs_q <= ASRO_DONE;
                  end else if (cnt_q != 6'h00 || !data_s) begin
                     sck_q <= 1'b1;
                     frame_q <= {frame_q[30:0], data_s};
                     cnt_q <= cnt_q + 6'h01;
                     hs_q <= ASRO_HIGH;
                  end
               end
            end
            ASRO_HIGH: begin
               div_q <= div_q + 8'h01;
               if (div_q == 8'(SCK_HALF_CYC - 1)) begin
                  div_q <= 8'h00;
                  sck_q <= 1'b0;
                  if (cnt_q == total_q) begin
                     hs_q <= ASRO_DONE;
                  end else begin
                     hs_q <= ASRO_LOW;
                  end
               end
            end
            ASRO_DONE: begin
               cs_n_q <= 1'b1;
               busy_q <= 1'b0;
               ready_q <= 1'b1;
               hs_q <= ASRO_IDLE;
            end
         endcase
      end
   end

   assign lnk.cs_n = cs_n_q;
   assign lnk.sck_host = sck_q;
   assign lnk.sck_host_oe = 1'b1; // external clock mode: host always drives
   assign HRDATA_O = rdata_q;
   assign HREADYOUT_O = 1'b1;
   assign HRESP_O = 1'b0;
   logic unused;
   assign unused = sck_s ^ sck_rise ^ data_fall ^ ^HSIZE_I;
endmodule

// file: test/asro_asserts.sv
// checker: select, framing and shift timing seen on the three-wire link
`timescale 1ns/1ps
module asro_asserts (
   input wire logic CLK_I,         // system clock
   input wire logic RSTN_I,        // async reset, active low
   input wire logic cs_n,          // chip select, active low
   input wire logic sck,           // resolved shift clock
   input wire logic serial_out,    // converter data
   input wire logic serial_out_oe, // converter drives data
   input wire logic data           // resolved data line
);
   logic sck_q;
   logic [5:0] rcnt_q;
   logic rise;
   logic fall;
   assign rise = sck && !sck_q;
   assign fall = !sck && sck_q;
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         sck_q <= 1'b0;
      end else begin
         sck_q <= sck;
      end
   end
   // rising edges within the current select window, saturating
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         rcnt_q <= 6'h00;
      end else if (cs_n) begin
         rcnt_q <= 6'h00;
      end else if (rise && rcnt_q != 6'h3f) begin
         rcnt_q <= rcnt_q + 6'h01;
      end
   end
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RSTN_I);
   ////////////////////////////////////////////////////////////////////////////////
   // six cycles leave room for the select synchroniser
   sequence sel_low_s; (!cs_n)[*6]; endsequence
   sequence sel_high_s; cs_n[*6]; endsequence
   sequence sck_held_s; (sck && !cs_n && rcnt_q != 6'h00)[*4]; endsequence
   oe_on_a: assert property (sel_low_s |-> serial_out_oe)
      else $error("data pin not driven while selected");
   oe_off_a: assert property (sel_high_s |-> !serial_out_oe)
      else $error("data pin driven while deselected");
   flag_first_a: assert property (rise && !cs_n && rcnt_q == 6'h00 |-> !data)
      else $error("completion flag not low at first rise");
   filler_a: assert property (rise && !cs_n && rcnt_q == 6'h01 |-> !data)
      else $error("filler bit not low");
   zero_tail_a: assert property (rise && !cs_n && rcnt_q >= 6'h14 && rcnt_q <= 6'h17 |-> !data)
      else $error("tail bit not low");
   extra_ones_a: assert property (rise && !cs_n && rcnt_q >= 6'h18
      |-> serial_out_oe && serial_out)
      else $error("extra clock did not read one");
   next_flag_a: assert property (fall && !cs_n && rcnt_q == 6'h18
      |-> ##[1:8] (cs_n || (serial_out_oe && serial_out)))
      else $error("next completion flag not driven high");
   flag_hold_a: assert property (!cs_n && rcnt_q == 6'h00 && serial_out_oe && !serial_out
      |=> (cs_n || rcnt_q != 6'h00 || !serial_out))
      else $error("completion flag rose again before clocking");
   shift_fall_a: assert property (sck_held_s |=> (cs_n || $stable(serial_out)))
      else $error("data changed while shift clock high");
endmodule

// file: test/testbench.sv
// testbench: AHB-driven host reading result frames from the converter end
`timescale 1ns/1ps
`define CHK(got, exp) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) begin \
         num_errors++; \
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp); \
      end \
   end
module testbench
   import asro_pkg::*;
;
   localparam logic signed [VAL_W:0] FSV = 18'sh10000;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic srst = 1'b0;
   logic signed [VAL_W:0] vin = 18'sh10007;
   logic hsel = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hready;
   logic hresp;
   logic done;
   logic [31:0] d;
   logic int_mode;
   int num_errors = 0;
   int n_tests = 0;
   // over, full scale, in-range corners, under
   logic signed [VAL_W:0] tv [8] = '{18'sh10007, 18'sh10000, 18'sh0ffff, 18'sh08000,
      18'sh00000, 18'sh3ffff, 18'sh30000, 18'sh2ffff};
   always #2 clk = ~clk;
   asro_if asro_if_i ();
   // conversion outlasts eight extra clocks, so all of them read one
   asro_dev #(.CONV_LEN(400)) asro_dev_i (.CLK_I(clk), .RSTN_I(rstn), .SRST_I(srst),
      .VIN_I(vin), .FS_I(FSV), .CONV_DONE_O(done), .INT_MODE_O(int_mode), .lnk(asro_if_i));
   asro_host asro_host_i (.CLK_I(clk), .RSTN_I(rstn), .HSEL_I(hsel), .HADDR_I(haddr),
      .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
      .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
      .lnk(asro_if_i));
   asro_asserts asro_asserts_i (.CLK_I(clk), .RSTN_I(rstn), .cs_n(asro_if_i.cs_n),
      .sck(asro_if_i.sck), .serial_out(asro_if_i.serial_out),
      .serial_out_oe(asro_if_i.serial_out_oe), .data(asro_if_i.data));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask
   // start a read sequence, poll busy, fetch the captured bits
   task automatic frame(input logic [31:0] ctrl, output logic [31:0] rd);
      logic [31:0] st;
      int i;
      ahb(1'b1, REG_CTRL, ctrl, st);
      st = 32'h2;
      for (i = 0; i < 20000 && st[1] !== 1'b0; i++) ahb(1'b0, REG_STAT, 32'h0, st);
      `CHK(st[1], 1'b0)
      ahb(1'b0, REG_DATA, 32'h0, rd);
   endtask
   task automatic wait_done();
      int i;
      for (i = 0; i < 20000 && done !== 1'b1; i++) @(negedge clk);
   endtask
   function automatic logic [23:0] fexp(input logic signed [VAL_W:0] v);
      logic [VAL_W:0] r;
      if (v >= FSV) r = 18'h30000;
      else if (v < -FSV) r = 18'h0ffff;
      else r = {~v[VAL_W], v[VAL_W-1:0]};
      return {2'h0, r, 4'h0};
   endfunction
   task automatic end_sim();
      $display("errors %0d, comparisons %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      ahb(1'b0, 8'h40, 32'h0, d);
      `CHK(d, 32'h0)
      `CHK(hresp, 1'b0)
      // first read starts the conversion of the new value, second checks it
      for (int i = 0; i < 8; i++) begin
         @(posedge clk) vin <= tv[i];
         frame(32'h1, d);
         frame(32'h1, d);
         `CHK(d[23:0], fexp(tv[i]))
      end
      // select pulse with no clocks must keep the held result
      wait_done();
      `CHK(done, 1'b1)
      @(posedge clk) vin <= 18'sh01234;
      frame(32'h0001_0001, d);
      frame(32'h1, d);
      `CHK(d[23:0], fexp(tv[7]))
      // abort after five clocks restarts with the current input
      @(posedge clk) vin <= 18'sh3fa98;
      frame(32'h0001_0501, d);
      frame(32'h1, d);
      `CHK(d[23:0], fexp(18'sh3fa98))
      frame(32'h0800_0001, d);
      `CHK(d, {fexp(18'sh3fa98), 8'hff})
      frame(32'h1, d);
      `CHK(d[23:0], fexp(18'sh3fa98))
      @(posedge clk) vin <= 18'sh00abc;
      @(posedge clk) srst <= 1'b1;
      @(posedge clk) srst <= 1'b0;
      wait_done();
      `CHK(done, 1'b1)
      frame(32'h1, d);
      `CHK(d[23:0], fexp(18'sh00abc))
      `CHK(int_mode, 1'b0)
      end_sim();
   end
   // roughly two and a half times the expected run length
   initial begin
      #300000;
      num_errors++;
      end_sim();
   end
endmodule
